// ---- rtl/pac_pkg.sv ----
/*
  Shared constants and types for the pager address classifier.
  Assumes a single 125 MHz clock domain; no software registers.
*/
package pac_pkg;

  // ----------------------------------------------------------------
  // Word ranges
  // ----------------------------------------------------------------
  localparam int          WORD_W     = 21;
  localparam logic [20:0] IDLE_ZERO  = 21'h000000;
  localparam logic [20:0] LONG1_HI   = 21'h008000;
  localparam logic [20:0] SHORT_HI   = 21'h1E0000;
  localparam logic [20:0] LONG3_HI   = 21'h1E8000;
  localparam logic [20:0] LONG4_HI   = 21'h1F0000;
  localparam logic [20:0] SRSV1_HI   = 21'h1F27FF;
  localparam logic [20:0] INFO_HI    = 21'h1F67FF;
  localparam logic [20:0] NET_HI     = 21'h1F77FF;
  localparam logic [20:0] TEMP_HI    = 21'h1F780F;
  localparam logic [20:0] OPER_HI    = 21'h1F781F;
  localparam logic [20:0] SRSV2_HI   = 21'h1F7FFE;
  localparam logic [20:0] IDLE_ONES  = 21'h1FFFFF;

  // ----------------------------------------------------------------
  // Address code fields
  // ----------------------------------------------------------------
  localparam int          CODE_W     = 33;
  localparam int          PH_LSB     = 2;
  localparam int          PH_MSB     = 3;
  localparam int          FR_LSB     = 4;
  localparam int          FR_MSB     = 10;
  localparam logic [32:0] VAL_MIN    = 33'h0_0000_0001;
  localparam logic [32:0] VAL_MAX    = 33'h1_4020_0FFE;
  localparam logic [32:0] SHORT_LIM  = 33'h0_001E_FFFF;
  localparam logic [32:0] LONG_LIM   = 33'h0_0020_1000;
  localparam logic [32:0] SET12_MAX  = 33'h0_4020_1000;
  localparam logic [3:0]  DIG_SHORT  = 4'h7;
  localparam logic [3:0]  DIG_SET12  = 4'h9;
  localparam logic [3:0]  DIG_LONG   = 4'hA;
  localparam logic [2:0]  BATT_DEF   = 3'h4;
  localparam logic [9:0]  FRAME_MAX  = 10'h07F;
  localparam logic [7:0]  CH_A       = 8'h41;
  localparam logic [7:0]  CH_D       = 8'h44;
  localparam logic [7:0]  CH_H       = 8'h48;
  localparam logic [7:0]  CH_L       = 8'h4C;
  localparam logic [7:0]  CH_P       = 8'h50;
  localparam logic [7:0]  CH_S       = 8'h53;
  localparam logic [7:0]  CH_U       = 8'h55;
  localparam logic [7:0]  CH_X       = 8'h58;
  localparam logic [7:0]  CH_Y       = 8'h59;
  localparam logic [7:0]  CH_Z       = 8'h5A;
  localparam logic [3:0]  ALL_PHASES = 4'hF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PAC_IDLE, PAC_LONG1, PAC_SHORT, PAC_LONG3, PAC_LONG4, PAC_SRSV,
    PAC_INFO, PAC_NET, PAC_TEMP, PAC_OPER, PAC_LONG2
  } pac_cls_t;

  typedef enum logic [2:0] {
    PAC_PAIR_NONE, PAC_PAIR_12, PAC_PAIR_13, PAC_PAIR_14,
    PAC_PAIR_23, PAC_PAIR_24
  } pac_pair_t;

  typedef enum logic [1:0] {
    PAC_SINGLE, PAC_ANY, PAC_ALL
  } pac_kind_t;

  typedef struct packed {
    logic [7:0]  letter;
    logic        has_batt;
    logic [2:0]  batt;
    logic        has_frame;
    logic [9:0]  frame;
    logic        has_ext;
    logic [7:0]  ext;
    logic [3:0]  digits;
    logic [32:0] value;
  } pac_code_t;

  typedef struct packed {
    pac_kind_t   kind;
    logic [1:0]  phase;
    logic [6:0]  frame;
    logic [2:0]  batt;
    logic        frame_known;
    logic        standard;
    logic        err;
  } pac_sched_t;

endpackage

// ---- rtl/pac_word_range.sv ----
/*
  Combinational range decoder for one 21-bit address word.
  Assumes the caller registers the result.
*/
`timescale 1ns/10ps
module pac_word_range
  import pac_pkg::*;
(
  input  wire logic [20:0] word_i,
  output pac_cls_t         cls_o
);

  // ----------------------------------------------------------------
  // Ordered upper-bound cascade
  // ----------------------------------------------------------------
  always_comb begin
    if (word_i == IDLE_ZERO || word_i == IDLE_ONES) begin
      cls_o = PAC_IDLE;
    end else if (word_i <= LONG1_HI) begin
      cls_o = PAC_LONG1;
    end else if (word_i <= SHORT_HI) begin
      cls_o = PAC_SHORT;
    end else if (word_i <= LONG3_HI) begin
      cls_o = PAC_LONG3;
    end else if (word_i <= LONG4_HI) begin
      cls_o = PAC_LONG4;
    end else if (word_i <= SRSV1_HI) begin
      cls_o = PAC_SRSV;
    end else if (word_i <= INFO_HI) begin
      cls_o = PAC_INFO;
    end else if (word_i <= NET_HI) begin
      cls_o = PAC_NET;
    end else if (word_i <= TEMP_HI) begin
      cls_o = PAC_TEMP;
    end else if (word_i <= OPER_HI) begin
      cls_o = PAC_OPER;
    end else if (word_i <= SRSV2_HI) begin
      cls_o = PAC_SRSV;
    end else begin
      cls_o = PAC_LONG2;
    end
  end

endmodule

// ---- rtl/pac_code_decode.sv ----
/*
  Combinational decoder of a textual pager_address_code into
  type, phase, frame and battery cycle. Result is registered above.
*/
`timescale 1ns/10ps
module pac_code_decode
  import pac_pkg::*;
(
  input  pac_code_t  code_i,
  output pac_sched_t sched_o
);

  logic std_l;
  logic non_l;
  logic [7:0] off_l;

  // ----------------------------------------------------------------
  // Letter class and field derivation
  // ----------------------------------------------------------------
  always_comb begin
    std_l = (code_i.letter >= CH_A) && (code_i.letter <= CH_L);
    non_l = (code_i.letter >= CH_U) && (code_i.letter <= CH_Z);
    off_l = code_i.letter - CH_U;
    sched_o = '0;
    sched_o.standard = std_l;
    if (std_l) begin
      // Phase bits 2-3 and frame bits 4-10 equal (value div 4) mod 4 and (value div 16) mod 128
      sched_o.phase = code_i.value[PH_MSB:PH_LSB];
      sched_o.frame = code_i.value[FR_MSB:FR_LSB];
      sched_o.frame_known = 1'b1;
      sched_o.batt = code_i.has_batt ? code_i.batt : BATT_DEF;
      if (code_i.letter <= CH_D) begin
        sched_o.kind = PAC_SINGLE;
      end else if (code_i.letter <= CH_H) begin
        sched_o.kind = PAC_ANY;
      end else begin
        sched_o.kind = PAC_ALL;
      end
    end else begin
      sched_o.phase = off_l[1:0];
      sched_o.frame = code_i.frame[6:0];
      sched_o.frame_known = code_i.has_frame;
      sched_o.batt = code_i.has_batt ? code_i.batt : BATT_DEF;
      if (code_i.letter <= CH_X) begin
        sched_o.kind = PAC_SINGLE;
      end else if (code_i.letter == CH_Y) begin
        sched_o.kind = PAC_ANY;
      end else begin
        sched_o.kind = PAC_ALL;
      end
    end
    // Malformed codes
    if (!std_l && !non_l) begin
      sched_o.err = 1'b1;
    end
    if (code_i.has_frame && (!non_l || code_i.frame > FRAME_MAX)) begin
      sched_o.err = 1'b1;
    end
    if (code_i.value < VAL_MIN || code_i.value > VAL_MAX) begin
      sched_o.err = 1'b1;
    end
    if (code_i.value >= SHORT_LIM && code_i.value <= LONG_LIM) begin
      sched_o.err = 1'b1;
    end
    if (code_i.value < SHORT_LIM) begin
      if (code_i.digits != DIG_SHORT) begin
        sched_o.err = 1'b1;
      end
    end else if (code_i.value <= SET12_MAX) begin
      if (code_i.digits != DIG_SET12 && code_i.digits != DIG_LONG) begin
        sched_o.err = 1'b1;
      end
    end else if (code_i.digits != DIG_LONG) begin
      sched_o.err = 1'b1;
    end
    if (code_i.has_ext) begin
      if (code_i.ext < CH_P || code_i.ext > CH_S || code_i.digits != DIG_LONG) begin
        sched_o.err = 1'b1;
      end
    end
  end

endmodule

// ---- rtl/pac_addr_classifier.sv ----
/*
  Pager address classifier top: classifies received address words,
  pairs long-address words, decodes a loaded pager_address_code and
  tells which phases and frames the decoder must watch.
  Assumes word, code and frame-tick inputs come from logic on sys_clk_i.
*/
`timescale 1ns/10ps
module pac_addr_classifier
  import pac_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        word_valid_i,
  input  wire logic [20:0] word_i,
  input  pac_code_t        code_i,
  input  wire logic        code_load_i,
  input  wire logic        frame_tick_i,
  input  wire logic [6:0]  cur_frame_i,
  output logic             word_valid_o,
  output pac_cls_t         word_class_o,
  output logic             addr_valid_o,
  output logic             addr_long_o,
  output pac_pair_t        pair_o,
  output logic [20:0]      addr_word1_o,
  output logic [20:0]      addr_word2_o,
  output logic             sched_valid_o,
  output pac_sched_t       sched_o,
  output logic [3:0]       phase_mask_o,
  output logic             watch_frame_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic {
    PAC_ST_WAIT, PAC_ST_HELD
  } pac_pst_t;

  pac_cls_t    cls_l;
  pac_sched_t  dec_l;
  pac_pst_t    pst_r;
  pac_pst_t    pst_nxt;
  pac_cls_t    first_cls_r;
  logic [20:0] first_word_r;
  pac_pair_t   pair_l;
  logic        is_long_first_l;
  logic        is_single_l;
  logic        emit_short_l;
  logic        emit_long_l;
  logic [3:0]  phase_sel_l;
  logic [6:0]  batt_mask_l;
  logic [6:0]  frame_diff_l;
  logic        sched_ok_r;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  pac_word_range u_range (
    .word_i (word_i),
    .cls_o  (cls_l)
  );

  pac_code_decode u_decode (
    .code_i  (code_i),
    .sched_o (dec_l)
  );

  // ----------------------------------------------------------------
  // Long-pair lookup
  // ----------------------------------------------------------------
  // Only the five legal orderings yield a pair
  always_comb begin
    pair_l = PAC_PAIR_NONE;
    if (first_cls_r == PAC_LONG1) begin
      if (cls_l == PAC_LONG2) begin
        pair_l = PAC_PAIR_12;
      end else if (cls_l == PAC_LONG3) begin
        pair_l = PAC_PAIR_13;
      end else if (cls_l == PAC_LONG4) begin
        pair_l = PAC_PAIR_14;
      end
    end else if (first_cls_r == PAC_LONG2) begin
      if (cls_l == PAC_LONG3) begin
        pair_l = PAC_PAIR_23;
      end else if (cls_l == PAC_LONG4) begin
        pair_l = PAC_PAIR_24;
      end
    end
  end

  // Word kinds that start a pair or stand alone
  always_comb begin
    is_long_first_l = (cls_l == PAC_LONG1) || (cls_l == PAC_LONG2);
    is_single_l     = (cls_l == PAC_SHORT) || (cls_l == PAC_INFO) ||
                      (cls_l == PAC_NET)   || (cls_l == PAC_TEMP) ||
                      (cls_l == PAC_OPER);
  end

  // ----------------------------------------------------------------
  // Pairing state machine
  // ----------------------------------------------------------------
  always_comb begin
    pst_nxt      = pst_r;
    emit_short_l = 1'b0;
    emit_long_l  = 1'b0;
    if (word_valid_i) begin
      case (pst_r)
        PAC_ST_WAIT: begin
          emit_short_l = is_single_l;
          if (is_long_first_l) begin
            pst_nxt = PAC_ST_HELD;
          end
        end
        PAC_ST_HELD: begin
          if (pair_l != PAC_PAIR_NONE) begin
            emit_long_l = 1'b1;
            pst_nxt     = PAC_ST_WAIT;
          end else if (is_long_first_l) begin
            pst_nxt = PAC_ST_HELD;
          end else begin
            emit_short_l = is_single_l;
            pst_nxt      = PAC_ST_WAIT;
          end
        end
        default: begin
          pst_nxt = PAC_ST_WAIT;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pst_r <= PAC_ST_WAIT;
    end else begin
      pst_r <= pst_nxt;
    end
  end

  // First word of a pending long address
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      first_cls_r  <= PAC_IDLE;
      first_word_r <= IDLE_ZERO;
    end else if (word_valid_i) begin
      if (pst_nxt == PAC_ST_HELD && is_long_first_l) begin
        first_cls_r  <= cls_l;
        first_word_r <= word_i;
      end else begin
        first_cls_r <= PAC_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Word classification outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      word_valid_o <= 1'b0;
      word_class_o <= PAC_IDLE;
    end else begin
      word_valid_o <= word_valid_i;
      if (word_valid_i) begin
        word_class_o <= cls_l;
      end
    end
  end

  // Accepted address outputs
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr_valid_o <= 1'b0;
      addr_long_o  <= 1'b0;
      pair_o       <= PAC_PAIR_NONE;
      addr_word1_o <= IDLE_ZERO;
      addr_word2_o <= IDLE_ZERO;
    end else begin
      addr_valid_o <= emit_short_l || emit_long_l;
      if (emit_long_l) begin
        addr_long_o  <= 1'b1;
        pair_o       <= pair_l;
        addr_word1_o <= first_word_r;
        addr_word2_o <= word_i;
      end else if (emit_short_l) begin
        addr_long_o  <= 1'b0;
        pair_o       <= PAC_PAIR_NONE;
        addr_word1_o <= word_i;
        addr_word2_o <= IDLE_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // Schedule from loaded address code
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sched_valid_o <= 1'b0;
      sched_o       <= '0;
      sched_ok_r    <= 1'b0;
    end else begin
      sched_valid_o <= code_load_i;
      if (code_load_i) begin
        sched_o    <= dec_l;
        sched_ok_r <= !dec_l.err && dec_l.frame_known;
      end
    end
  end

  // Phase select and battery mask, one bit per entry
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_phase
      assign phase_sel_l[gi] = (dec_l.phase == 2'(gi));
    end
    for (gi = 0; gi < 7; gi++) begin : g_mask
      assign batt_mask_l[gi] = (sched_o.batt > 3'(gi));
    end
  endgenerate

  // Monitored phases: one for single-phase, all four for any/all, none for an erroneous code
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_mask_o <= '0;
    end else if (code_load_i) begin
      if (dec_l.err) begin
        phase_mask_o <= '0;
      end else if (dec_l.kind == PAC_SINGLE) begin
        phase_mask_o <= phase_sel_l;
      end else begin
        phase_mask_o <= ALL_PHASES;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame watch
  // ----------------------------------------------------------------
  // Seven-bit difference wraps over the 128-frame cycle
  assign frame_diff_l = cur_frame_i - sched_o.frame;

  // Watch on the assigned frame and every 2^b frames after it
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      watch_frame_o <= 1'b0;
    end else if (frame_tick_i) begin
      watch_frame_o <= sched_ok_r && ((frame_diff_l & batt_mask_l) == '0);
    end else begin
      watch_frame_o <= 1'b0;
    end
  end

endmodule

// ---- tb/pac_addr_classifier_props.sv ----
/*
  Port-level checks on the pager address classifier top.
  Assumes one clock and the active-low asynchronous reset.
*/
`timescale 1ns/10ps
module pac_addr_classifier_props
  import pac_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        resetn_i,
  input wire logic        word_valid_i,
  input wire logic [20:0] word_i,
  input wire logic        code_load_i,
  input wire logic        word_valid_o,
  input pac_cls_t         word_class_o,
  input wire logic        addr_valid_o,
  input wire logic        addr_long_o,
  input pac_pair_t        pair_o,
  input wire logic [20:0] addr_word1_o,
  input wire logic        sched_valid_o,
  input pac_sched_t       sched_o,
  input wire logic [3:0]  phase_mask_o,
  input wire logic        frame_tick_i,
  input wire logic [6:0]  cur_frame_i,
  input wire logic        watch_frame_o
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  a_word_echo: assert property (word_valid_i |=> word_valid_o)
    else $error("word strobe not echoed");
  a_no_echo: assert property (!word_valid_i |=> !word_valid_o && !addr_valid_o)
    else $error("output strobe without word");
  a_idle_drop: assert property (
    word_valid_i && (word_i == 21'h000000 || word_i == 21'h1FFFFF) |=> !addr_valid_o)
    else $error("idle word accepted");
  a_short_take: assert property (
    word_valid_i && word_i inside {[21'h008001:21'h1E0000]} |=> addr_valid_o
    && !addr_long_o && addr_word1_o == $past(word_i) && word_class_o == PAC_SHORT)
    else $error("short word not accepted");
  a_pair_13: assert property (
    word_valid_i && $past(word_valid_i) && $past(word_i) inside {[21'h000001:21'h008000]}
    && word_i inside {[21'h1E0001:21'h1E8000]} |=> addr_valid_o && addr_long_o
    && pair_o == PAC_PAIR_13)
    else $error("pair 1-3 not formed");
  a_long2_cls: assert property (
    word_valid_i && word_i inside {[21'h1F7FFF:21'h1FFFFE]} |=> word_class_o == PAC_LONG2)
    else $error("long word 2 misclassified");
  a_sched_strobe: assert property (code_load_i |=> sched_valid_o)
    else $error("schedule strobe missing");
  a_single_mask: assert property (
    sched_valid_o && !sched_o.err && sched_o.kind == PAC_SINGLE
    |-> phase_mask_o == (4'h1 << sched_o.phase))
    else $error("single phase mask wrong");
  a_watch_cause: assert property (watch_frame_o |-> $past(frame_tick_i))
    else $error("frame watch without tick");
  a_watch_step: assert property (
    watch_frame_o && !$past(code_load_i) |-> ((($past(cur_frame_i) - sched_o.frame)
    & ~(7'h7F << sched_o.batt)) == 7'h00))
    else $error("frame watched off cycle");
endmodule

bind pac_addr_classifier pac_addr_classifier_props u_props (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .word_valid_i(word_valid_i),
  .word_i(word_i), .code_load_i(code_load_i), .word_valid_o(word_valid_o),
  .word_class_o(word_class_o), .addr_valid_o(addr_valid_o), .addr_long_o(addr_long_o),
  .pair_o(pair_o), .addr_word1_o(addr_word1_o), .sched_valid_o(sched_valid_o),
  .sched_o(sched_o), .phase_mask_o(phase_mask_o), .frame_tick_i(frame_tick_i),
  .cur_frame_i(cur_frame_i), .watch_frame_o(watch_frame_o)
);

// ---- tb/pac_chan_model.sv ----
/*
  Model of the demodulated channel presenting decoded address words.
  Assumes the bench calls send from its main sequence.
*/
`timescale 1ns/10ps
module pac_chan_model (
  input  wire logic        clk_i,
  output logic             valid_o,
  output logic [20:0]      word_o
);
  // ----------------------------------------------------------------
  // Word delivery
  // ----------------------------------------------------------------
  initial begin
    valid_o = 1'b0;
    word_o  = 21'h0AAAAA;
  end

  // One word per cycle; strobe held when another word follows
  task automatic send(input logic [20:0] w, input bit last);
    @(negedge clk_i);
    valid_o <= 1'b1;
    word_o  <= w;
    if (last) begin
      @(negedge clk_i);
      valid_o <= 1'b0;
      word_o  <= ~w; // Released line shows no stale word
    end
  endtask
endmodule

// ---- tb/test_pac_addr_classifier.sv ----
/*
  Self-checking bench for the pager address classifier.
  Assumes the channel model and the bound port checker.
*/
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("BAD %0t got %0h exp %0h", $time, got, exp); end end
module test_pac_addr_classifier;
  import pac_pkg::*;
  logic        sys_clk_i = 0, resetn_i = 0, code_load_i = 0, frame_tick_i = 0;
  logic        word_valid_i, word_valid_o, addr_valid_o, addr_long_o;
  logic        sched_valid_o, watch_frame_o;
  logic [6:0]  cur_frame_i = 0;
  logic [20:0] word_i, addr_word1_o, addr_word2_o;
  logic [3:0]  phase_mask_o;
  pac_code_t   code_i = '0;
  pac_cls_t    word_class_o;
  pac_pair_t   pair_o;
  pac_sched_t  sched_o;
  int          fail_count = 0, check_count = 0, cycles = 0;

  pac_chan_model chan (.clk_i(sys_clk_i), .valid_o(word_valid_i), .word_o(word_i));
  pac_addr_classifier dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .word_valid_i(word_valid_i), .word_i(word_i), .code_i(code_i),
    .code_load_i(code_load_i), .frame_tick_i(frame_tick_i), .cur_frame_i(cur_frame_i),
    .word_valid_o(word_valid_o), .word_class_o(word_class_o), .addr_valid_o(addr_valid_o),
    .addr_long_o(addr_long_o), .pair_o(pair_o), .addr_word1_o(addr_word1_o),
    .addr_word2_o(addr_word2_o), .sched_valid_o(sched_valid_o), .sched_o(sched_o),
    .phase_mask_o(phase_mask_o), .watch_frame_o(watch_frame_o));

  // ----------------------------------------------------------------
  // Clock, watchdog and verdict
  // ----------------------------------------------------------------
  always #4 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  function automatic pac_code_t mk(logic [7:0] l, logic hb, logic [2:0] b, logic hf,
                                   logic [9:0] f, logic [3:0] d, logic [32:0] v);
    mk = '{letter:l, has_batt:hb, batt:b, has_frame:hf, frame:f, has_ext:1'b0,
           ext:8'h00, digits:d, value:v};
  endfunction

  task automatic load(input pac_code_t c);
    @(negedge sys_clk_i);
    code_i      <= c;
    code_load_i <= 1'b1;
    @(negedge sys_clk_i);
    code_load_i <= 1'b0;
    `CHK(sched_valid_o, 1'b1)
  endtask

  task automatic tick(input logic [6:0] f, input logic exp);
    @(negedge sys_clk_i);
    frame_tick_i <= 1'b1;
    cur_frame_i  <= f;
    @(negedge sys_clk_i);
    frame_tick_i <= 1'b0;
    `CHK(watch_frame_o, exp)
  endtask

  task automatic pair(input logic [20:0] a, b, input logic ok, input pac_pair_t p);
    chan.send(a, 1'b0);
    chan.send(b, 1'b1);
    `CHK(addr_valid_o, ok)
    if (ok) begin
      `CHK(pair_o, p)
      `CHK(addr_long_o, 1'b1)
      `CHK({addr_word1_o, addr_word2_o}, {a, b})
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Both edges of every word range, one word at a time
  task automatic t_classes();
    logic [20:0] lo [13] = '{21'h000000, 21'h000001, 21'h008001, 21'h1E0001, 21'h1E8001,
      21'h1F0001, 21'h1F2800, 21'h1F6800, 21'h1F7800, 21'h1F7810, 21'h1F7820,
      21'h1F7FFF, 21'h1FFFFF};
    pac_cls_t c [13] = '{PAC_IDLE, PAC_LONG1, PAC_SHORT, PAC_LONG3, PAC_LONG4, PAC_SRSV,
      PAC_INFO, PAC_NET, PAC_TEMP, PAC_OPER, PAC_SRSV, PAC_LONG2, PAC_IDLE};
    logic [20:0] w;
    for (int i = 0; i < 25; i++) begin
      w = (i % 2 == 0) ? lo[i / 2] : lo[i / 2 + 1] - 21'h000001;
      chan.send(w, 1'b1);
      `CHK(word_class_o, c[i / 2])
      `CHK(addr_valid_o, 1'(c[i / 2] inside {PAC_SHORT, PAC_INFO, PAC_NET, PAC_TEMP,
           PAC_OPER}))
    end
  endtask

  // Every legal pairing, then refused orders
  task automatic t_pairs();
    pair(21'h000001, 21'h1F8000, 1'b1, PAC_PAIR_12);
    pair(21'h008000, 21'h1E0001, 1'b1, PAC_PAIR_13);
    pair(21'h000005, 21'h1F0000, 1'b1, PAC_PAIR_14);
    pair(21'h1FFFFE, 21'h1E8000, 1'b1, PAC_PAIR_23);
    pair(21'h1F7FFF, 21'h1E8001, 1'b1, PAC_PAIR_24);
    chan.send(21'h000000, 1'b1);
    pair(21'h1E0001, 21'h1E8001, 1'b0, PAC_PAIR_NONE);
    pair(21'h1F8000, 21'h000001, 1'b0, PAC_PAIR_NONE);
    chan.send(21'h008001, 1'b0);
    chan.send(21'h1E0001, 1'b1);
    `CHK(addr_valid_o, 1'b0)
    chan.send(21'h000002, 1'b1);
    chan.send(21'h1F9000, 1'b1);
    `CHK(pair_o, PAC_PAIR_12)
  endtask

  // Standard and non-standard letters, then refused codes
  task automatic t_codes();
    logic [32:0] v;
    pac_kind_t   k;
    pac_code_t   bad [9];
    for (int i = 0; i < 12; i++) begin
      v = 33'd1234560 + 33'(4 * i);
      load(mk(8'h41 + 8'(i), i[0], 3'(i), 1'b0, 10'h000, 4'h7, v));
      k = (i < 4) ? PAC_SINGLE : (i < 8) ? PAC_ANY : PAC_ALL;
      `CHK(sched_o.kind, k)
      `CHK({sched_o.phase, sched_o.frame}, {v[3:2], v[10:4]})
      `CHK(sched_o.batt, i[0] ? 3'(i) : 3'h4)
      `CHK(phase_mask_o, (k == PAC_SINGLE) ? 4'(4'h1 << v[3:2]) : 4'hF)
    end
    for (int j = 0; j < 6; j++) begin
      load(mk(8'h55 + 8'(j), 1'b1, 3'(j), 1'b1, 10'(100 + j), 4'h7, 33'd1234567));
      k = (j < 4) ? PAC_SINGLE : (j == 4) ? PAC_ANY : PAC_ALL;
      `CHK(sched_o.kind, k)
      `CHK({sched_o.frame, sched_o.standard}, {7'(100 + j), 1'b0})
      `CHK(phase_mask_o, (j < 4) ? 4'(4'h1 << j) : 4'hF)
    end
    bad[0] = mk(8'h4D, 1'b0, 3'h0, 1'b0, 10'h000, 4'h7, 33'd1234567);
    bad[1] = mk(8'h41, 1'b0, 3'h0, 1'b1, 10'h005, 4'h7, 33'd1234567);
    bad[2] = mk(8'h55, 1'b0, 3'h0, 1'b1, 10'd128, 4'h7, 33'd1234567);
    bad[3] = mk(8'h41, 1'b0, 3'h0, 1'b0, 10'h000, 4'h7, 33'd0);
    bad[4] = mk(8'h41, 1'b0, 3'h0, 1'b0, 10'h000, 4'h7, 33'd2031615);
    bad[5] = mk(8'h41, 1'b0, 3'h0, 1'b0, 10'h000, 4'h8, 33'd1234567);
    bad[6] = mk(8'h45, 1'b0, 3'h0, 1'b0, 10'h000, 4'hA, 33'd5370810367);
    bad[7] = mk(8'h41, 1'b0, 3'h0, 1'b0, 10'h000, 4'h7, 33'd1234567);
    bad[7].has_ext = 1'b1;
    bad[7].ext = 8'h52;
    bad[8] = mk(8'h45, 1'b0, 3'h0, 1'b0, 10'h000, 4'hA, 33'd3000000000);
    bad[8].has_ext = 1'b1;
    bad[8].ext = 8'h54;
    for (int i = 0; i < 9; i++) begin
      load(bad[i]);
      `CHK({sched_o.err, phase_mask_o}, 5'h10)
    end
    bad[8].ext = 8'h50;
    load(bad[8]);
    `CHK(sched_o.err, 1'b0)
    load(mk(8'h49, 1'b0, 3'h0, 1'b0, 10'h000, 4'h9, 33'd500000000));
    `CHK(sched_o.err, 1'b0)
    load(mk(8'h41, 1'b0, 3'h0, 1'b0, 10'h000, 4'h7, 33'd2031614));
    `CHK(sched_o.err, 1'b0)
  endtask

  // Frame watching over all frames at battery cycle 5, then battery cycles 4 and 0
  task automatic t_frames();
    load(mk(8'h55, 1'b1, 3'h5, 1'b1, 10'h003, 4'h7, 33'd1234567));
    for (int f = 0; f < 128; f++) tick(7'(f), 1'((7'(f) - 7'h03) % 32 == 0));
    load(mk(8'h41, 1'b0, 3'h0, 1'b0, 10'h000, 4'h7, 33'h035));
    tick(7'd19, 1'b1);
    tick(7'd11, 1'b0);
    load(mk(8'h42, 1'b1, 3'h0, 1'b0, 10'h000, 4'h7, 33'h035));
    tick(7'd77, 1'b1);
    load(mk(8'h59, 1'b0, 3'h0, 1'b0, 10'h000, 4'h7, 33'd1234567));
    tick(7'd3, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    `CHK({addr_valid_o, word_class_o, pair_o, phase_mask_o}, 12'h000)
    t_classes();
    t_pairs();
    t_codes();
    t_frames();
    summarize();
  end
endmodule
